// >>> design/ombs_mode_ctrl.sv
// operating mode register, boot source select and stop-exit delay
// Functional notes
// - at reset mode bits 4,1,0 take the three mode pins
// - after reset software may rewrite the mode bits
// - program-RAM enable bits 2 and 3 select memory map, cleared by reset
// - stop exit with delay bit clear waits 65535 core cycles
// - stop exit with delay bit set waits eight core cycles
// - decode 000 normal, 001 parallel host boot, 010 ROM wake
// - 101 serial SPI slave boot, 111 serial I2C slave boot
// - mode 0 selects no boot source and disables boot ROM
// - mode 0 at reset is forced to mode 1
// - mode 3 at reset starts as mode 1
// - mode 4 at reset starts as mode 2
// - mode 6 at reset starts as mode 2
// - mode 1 boots up to 512 words over the parallel host port
// - mode 2 boots then continues at ROM address 0b00
// - modes 5 and 7 load 512 24-bit words over serial port
// - unused bus control register stays active, cleared by reset
// - debug port enabled from hardware reset
`timescale 1ns/1ps
`include "ombs_map.svh"
module ombs_mode_ctrl import ombs_pkg::*; #(
	parameter int STOP_LONG_CYC = `OMBS_STOP_LONG_CYC,
	parameter int STOP_SHORT_CYC = `OMBS_STOP_SHORT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// mode pins, asynchronous
	input wire logic mode_pin_2,
	input wire logic mode_pin_1,
	input wire logic mode_pin_0,
	// core register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	output logic [23:0] reg_rdata,
	// stop handshake
	input wire logic stop_exit,
	output logic stop_done,
	// boot, memory map and debug outputs
	output ombs_boot_t boot_sel,
	output ombs_pe_t pe_sel,
	output logic [15:0] boot_start_addr,
	output logic [9:0] boot_word_count,
	output logic debug_port_en
);
	// ==========================================================
	// pin synchronisers
	logic [2:0] pin_s1_q, pin_s2_q;
	always_ff @(posedge clk) begin
		pin_s1_q <= {mode_pin_2, mode_pin_1, mode_pin_0};
		pin_s2_q <= pin_s1_q;
	end

	// ==========================================================
	// reset remap of strapped mode
	function automatic logic [2:0] remap(input logic [2:0] m);
		case (m)
			3'h0: remap = 3'h1;
			3'h3: remap = 3'h1;
			3'h4: remap = 3'h2;
			3'h6: remap = 3'h2;
			default: remap = m;
		endcase
	endfunction : remap

	// ==========================================================
	// mode register and unused bus control
	logic [23:0] mreg_q, mreg_d, ubc_q, ubc_d, rdata_q, rdata_d;
	logic strap_q, strap_d;
	logic [2:0] mode;
	logic [2:0] strap_mode;
	assign strap_mode = remap(pin_s2_q);
	assign mode = {mreg_q[`OMBS_BIT_SEL2], mreg_q[`OMBS_BIT_SEL1],
		mreg_q[`OMBS_BIT_SEL0]};
	always_comb begin
		mreg_d = mreg_q;
		ubc_d = ubc_q;
		strap_d = 1'b0;
		rdata_d = rdata_q;
		// strap caught on the first clock after release, pins synced
		if (strap_q) begin
			mreg_d[`OMBS_BIT_SEL2] = strap_mode[2];
			mreg_d[`OMBS_BIT_SEL1] = strap_mode[1];
			mreg_d[`OMBS_BIT_SEL0] = strap_mode[0];
		end else if (reg_wr && reg_addr == `OMBS_ADDR_MODE) begin
			mreg_d = reg_wdata & `OMBS_MODE_MASK;
		end
		if (reg_wr && reg_addr == `OMBS_ADDR_UBC) begin
			ubc_d = reg_wdata;
		end
		if (reg_rd) begin
			case (reg_addr)
				`OMBS_ADDR_MODE: rdata_d = mreg_q;
				`OMBS_ADDR_UBC: rdata_d = ubc_q;
				default: rdata_d = 24'h000000;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mreg_q <= 24'h000000;
			ubc_q <= `OMBS_UBC_RST;
			strap_q <= 1'b1;
			rdata_q <= 24'h000000;
		end else begin
			mreg_q <= mreg_d;
			ubc_q <= ubc_d;
			strap_q <= strap_d;
			rdata_q <= rdata_d;
		end
	end

	// ==========================================================
	// boot source decode
	ombs_boot_t boot_d, boot_q;
	logic [15:0] start_d, start_q;
	logic [9:0] words_d, words_q;
	always_comb begin
		boot_d = '0;
		start_d = 16'h0000;
		words_d = 10'h000;
		case (mode)
			3'h0: boot_d.src = OMBS_SRC_NONE;
			3'h1: begin
				boot_d.src = OMBS_SRC_PHOST;
				boot_d.boot_rom_en = 1'b1;
				words_d = 10'(`OMBS_BOOT_WORDS);
			end
			3'h2: begin
				boot_d.src = OMBS_SRC_ROM;
				boot_d.boot_rom_en = 1'b1;
				start_d = `OMBS_ROM_START;
			end
			3'h5, 3'h7: begin
				boot_d.src = OMBS_SRC_SERIAL;
				boot_d.serial_i2c = mode[1];
				boot_d.boot_rom_en = 1'b1;
				words_d = 10'(`OMBS_BOOT_WORDS);
			end
			// reserved codes written by software: no boot source
			default: boot_d = '0;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			boot_q <= '0;
			start_q <= 16'h0000;
			words_q <= 10'h000;
		end else begin
			boot_q <= boot_d;
			start_q <= start_d;
			words_q <= words_d;
		end
	end

	// ==========================================================
	// stop exit delay
	ombs_stop_timer #(
		.LONG_CYC(STOP_LONG_CYC),
		.SHORT_CYC(STOP_SHORT_CYC)
	) u_stop (
		.clk(clk),
		.rstn(rstn),
		.start(stop_exit),
		.short_sel(mreg_q[`OMBS_BIT_STOP_SHORT]),
		.done(stop_done)
	);

	// ==========================================================
	// outputs
	logic dbg_q;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dbg_q <= 1'b1;
		end else begin
			dbg_q <= 1'b1;
		end
	end
	assign reg_rdata = rdata_q;
	assign boot_sel = boot_q;
	// map switch lands one clock after write; software allows slack
	assign pe_sel = {mreg_q[`OMBS_BIT_RAM_EN_B],
		mreg_q[`OMBS_BIT_RAM_EN_A]};
	assign boot_start_addr = start_q;
	assign boot_word_count = words_q;
	assign debug_port_en = dbg_q;

	// ==========================================================
	// checks
	a_strap_remap: assert property (@(posedge clk) disable iff (!rstn)
		strap_q |=> mode != 3'h0 && mode != 3'h3
		&& mode != 3'h4 && mode != 3'h6)
		else $error("reserved mode after strap");
	a_pe_reset: assert property (@(posedge clk)
		$past(!rstn) |-> pe_sel == 2'b00)
		else $error("memory map bits not cleared by reset");
	a_unused_read: assert property (@(posedge clk) disable iff (!rstn)
		reg_rd && reg_addr == `OMBS_ADDR_MODE |=>
		(reg_rdata & 24'hffffa0) == 0)
		else $error("unassigned mode bits read nonzero");
	a_sw_write: assert property (@(posedge clk) disable iff (!rstn)
		reg_wr && !strap_q && reg_addr == `OMBS_ADDR_MODE |=>
		mreg_q == ($past(reg_wdata) & `OMBS_MODE_MASK))
		else $error("mode write lost");
	a_rom_start: assert property (@(posedge clk) disable iff (!rstn)
		mode == 3'h2 |=> boot_start_addr == 16'h0b00)
		else $error("rom start wrong");
	a_serial_sel: assert property (@(posedge clk) disable iff (!rstn)
		mode == 3'h7 |=> boot_sel.src == OMBS_SRC_SERIAL
		&& boot_sel.serial_i2c)
		else $error("i2c boot not selected");
	a_mode0_ram: assert property (@(posedge clk) disable iff (!rstn)
		mode == 3'h0 |=> !boot_sel.boot_rom_en)
		else $error("boot rom on in mode 0");
	a_short_stop: assert property (@(posedge clk) disable iff (!rstn)
		stop_exit && mreg_q[`OMBS_BIT_STOP_SHORT] && !u_stop.busy_q
		|-> ##9 stop_done)
		else $error("short stop delay wrong");
	a_debug_on: assert property (@(posedge clk) disable iff (!rstn)
		debug_port_en)
		else $error("debug port off");
endmodule : ombs_mode_ctrl

// >>> design/ombs_map.svh
// offsets, field positions, reset values and timing counts of the mode block
`ifndef OMBS_MAP_SVH
`define OMBS_MAP_SVH
`define OMBS_ADDR_UBC 16'hfffe
`define OMBS_ADDR_MODE 16'hfff0
`define OMBS_BIT_SEL0 0
`define OMBS_BIT_SEL1 1
`define OMBS_BIT_RAM_EN_A 2
`define OMBS_BIT_RAM_EN_B 3
`define OMBS_BIT_SEL2 4
`define OMBS_BIT_STOP_SHORT 6
`define OMBS_MODE_MASK 24'h00005f
`define OMBS_UBC_RST 24'h000000
`define OMBS_STOP_LONG_CYC 65535
`define OMBS_STOP_SHORT_CYC 8
`define OMBS_STOP_CNT_W 16
`define OMBS_BOOT_WORDS 512
`define OMBS_ROM_START 16'h0b00
`endif

// >>> design/ombs_pkg.sv
// types of the mode and boot select block
package ombs_pkg;
	typedef enum logic [1:0] {
		OMBS_SRC_NONE,
		OMBS_SRC_PHOST,
		OMBS_SRC_ROM,
		OMBS_SRC_SERIAL
	} ombs_src_t;
	typedef struct packed {
		logic boot_rom_en;
		logic serial_i2c;
		ombs_src_t src;
	} ombs_boot_t;
	typedef struct packed {
		logic prog_ram_enable_b;
		logic prog_ram_enable_a;
	} ombs_pe_t;
endpackage : ombs_pkg

// >>> design/ombs_stop_timer.sv
// stop-exit delay counter
`timescale 1ns/1ps
`include "ombs_map.svh"
module ombs_stop_timer import ombs_pkg::*; #(
	parameter int LONG_CYC = `OMBS_STOP_LONG_CYC,
	parameter int SHORT_CYC = `OMBS_STOP_SHORT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// control
	input wire logic start,
	input wire logic short_sel,
	// status
	output logic done
);
	logic [`OMBS_STOP_CNT_W-1:0] cnt_q, cnt_d;
	logic busy_q, busy_d, done_q, done_d;
	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (start && !busy_q) begin
			busy_d = 1'b1;
			cnt_d = short_sel ? SHORT_CYC[`OMBS_STOP_CNT_W-1:0] - 1'b1
				: LONG_CYC[`OMBS_STOP_CNT_W-1:0] - 1'b1;
		end else if (busy_q) begin
			if (cnt_q == '0) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end else begin
				cnt_d = cnt_q - 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end
	assign done = done_q;
endmodule : ombs_stop_timer

// >>> verif/ombs_strap_model.sv
// strap model that drives the three mode pins
`timescale 1ns/1ps
module ombs_strap_model (
	// strap selection
	input wire logic [2:0] code,
	// mode pins
	output logic mode_pin_2,
	output logic mode_pin_1,
	output logic mode_pin_0
);
	// ==========================================================
	// straps
	// static levels; bench holds code steady across reset
	assign mode_pin_2 = code[2];
	assign mode_pin_1 = code[1];
	assign mode_pin_0 = code[0];
endmodule : ombs_strap_model

// >>> verif/operating_mode_boot_select_tb.sv
// self-checking bench of the mode and boot select block
`timescale 1ns/1ps
`include "ombs_map.svh"
module operating_mode_boot_select_tb import ombs_pkg::*; ;
	// ==========================================================
	// signals
	localparam int LONG_T = 20;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [23:0] reg_wdata = 24'h000000;
	logic [23:0] reg_rdata;
	logic stop_exit = 1'b0;
	logic stop_done;
	logic [2:0] strap = 3'h0;
	logic mode_pin_2, mode_pin_1, mode_pin_0;
	ombs_boot_t boot_sel;
	ombs_pe_t pe_sel;
	logic [15:0] boot_start_addr;
	logic [9:0] boot_word_count;
	logic debug_port_en;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	// ==========================================================
	// instances
	// short long-delay count keeps the run brief
	ombs_mode_ctrl #(.STOP_LONG_CYC(LONG_T)) ombs_mode_ctrl_inst (
		.clk(clk), .rstn(rstn), .mode_pin_2(mode_pin_2),
		.mode_pin_1(mode_pin_1), .mode_pin_0(mode_pin_0),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.stop_exit(stop_exit), .stop_done(stop_done),
		.boot_sel(boot_sel), .pe_sel(pe_sel),
		.boot_start_addr(boot_start_addr),
		.boot_word_count(boot_word_count), .debug_port_en(debug_port_en));
	ombs_strap_model ombs_strap_model_inst (.code(strap),
		.mode_pin_2(mode_pin_2), .mode_pin_1(mode_pin_1),
		.mode_pin_0(mode_pin_0));
	// ==========================================================
	// clock and timeout
	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// ==========================================================
	// tasks
	task automatic end_sim();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [23:0] seen,
		input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [23:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [23:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
	task automatic do_reset(input logic [2:0] code);
		@(posedge clk);
		strap <= code;
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : do_reset
	task automatic stop_chk(input logic [23:0] mval, input int exp);
		int n;
		wr(`OMBS_ADDR_MODE, mval);
		@(posedge clk);
		stop_exit <= 1'b1;
		@(posedge clk);
		stop_exit <= 1'b0;
		n = 0;
		@(negedge clk);
		while (stop_done !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk("stop_delay", 24'(n), 24'(exp));
	endtask : stop_chk
	// ==========================================================
	// expectations
	function automatic logic [2:0] remap(input logic [2:0] p);
		case (p)
			3'h0, 3'h3: remap = 3'h1;
			3'h4, 3'h6: remap = 3'h2;
			default: remap = p;
		endcase
	endfunction : remap
	function automatic logic [3:0] boot_of(input logic [2:0] m);
		case (m)
			3'h1: boot_of = 4'h9;
			3'h2: boot_of = 4'ha;
			3'h5: boot_of = 4'hb;
			3'h7: boot_of = 4'hf;
			default: boot_of = 4'h0;
		endcase
	endfunction : boot_of
	// ==========================================================
	// tests
	initial begin
		logic [23:0] d;
		logic [2:0] m;
		for (int i = 0; i < 8; i++) begin
			do_reset(3'(i));
			m = remap(3'(i));
			rd(`OMBS_ADDR_MODE, d);
			chk("mode_reg", d, {19'h0, m[2], 2'h0, m[1:0]});
			chk("boot_sel", 24'(boot_sel), 24'(boot_of(m)));
			chk("start_addr", 24'(boot_start_addr),
				(m == 3'h2) ? 24'h000b00 : 24'h000000);
			chk("word_count", 24'(boot_word_count),
				(m == 3'h1 || m[0] & m[2]) ? 24'h000200 : 24'h000000);
			chk("pe_sel", 24'(pe_sel), 24'h000000);
			chk("debug_en", 24'(debug_port_en), 24'h000001);
			// bus control is only read, never written
			rd(`OMBS_ADDR_UBC, d);
			chk("unused_bus_ctl", d, 24'h000000);
		end
		wr(`OMBS_ADDR_MODE, 24'hffffff);
		// let the memory map settle before relying on it
		rd(`OMBS_ADDR_MODE, d);
		chk("mode_reg_all", d, 24'h00005f);
		chk("pe_sel_set", 24'(pe_sel), 24'h000003);
		wr(`OMBS_ADDR_MODE, 24'h000000);
		repeat (2) @(negedge clk);
		chk("boot_sel_m0", 24'(boot_sel), 24'h000000);
		rd(16'h1234, d);
		chk("unmapped", d, 24'h000000);
		stop_chk(24'h000040, 8);
		stop_chk(24'h000000, LONG_T);
		end_sim();
	end
endmodule : operating_mode_boot_select_tb
